/* cps_device.sv */
`include "cps_params.svh"

// Behaviour
// - Select high at toggle enters diagnostic mode
// - Select low at toggle leaves diagnostic mode
// - Toggle sets active side and integration length
// - Continuous mode chosen from period length
// - Input steering open; only diagnostic switches used
// - Ground switch closed during diagnostic mode
// - One packet at each diagnostic integration start
// - Reference opens, dump closes, then recharge
// - Next dump starts as soon as the sequencer is idle
// - Integration and conversion same in both modes
// - Each select rise in diagnostic mode adds one packet
// - Controller restores select high before toggle
// - Select rises spaced at least 5.4 us
// - Extra packets capped at period over spacing
// - Diagnostic result depends only on packet count
// - Charge digitized to 20-bit word per integration
module cps_device
  import cps_pkg::*;
#(
  parameter int RES_W = `CPS_RES_W,
  parameter int CNT_W = `CPS_CNT_W,
  parameter int PEND_W = `CPS_PEND_W,
  parameter logic [31:0] CONT_MIN_CYC = `CPS_CONT_MIN_CYC,
  parameter logic [31:0] PKT_CHARGE = `CPS_PKT_CHARGE
) (
  input wire logic clk_i,
  input wire logic reset_i,
  cps_link_if.dev link,
  input wire logic [7:0] sensor_charge_i,
  output logic diag_mode_o,
  output logic active_side_o,
  output logic continuous_mode_o,
  output logic side_a_input_switch_o,
  output logic side_b_input_switch_o,
  output logic ground_switch_o,
  output logic side_a_dump_switch_o,
  output logic side_b_dump_switch_o,
  output logic reference_charge_switch_o,
  output logic [RES_W-1:0] result_o,
  output logic result_side_o,
  output logic result_valid_o
);

  localparam logic [15:0] BREAK_CYC = 16'(`CPS_BREAK_CYC);
  localparam logic [15:0] DUMP_CYC = 16'(`CPS_DUMP_CYC);
  localparam logic [15:0] RECH_CYC = 16'(`CPS_RECHARGE_CYC);

  // ========================================================================
  // Pin synchronisers and edge detection
  logic conv_s1_reg;
  logic conv_s2_reg;
  logic conv_s3_reg;
  logic sel_s1_reg;
  logic sel_s2_reg;
  logic sel_s3_reg;
  logic toggle;
  logic sel_rise;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_s1_reg <= 1'b0;
      conv_s2_reg <= 1'b0;
      conv_s3_reg <= 1'b0;
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
      sel_s3_reg <= 1'b0;
    end else begin
      conv_s1_reg <= link.conv;
      conv_s2_reg <= conv_s1_reg;
      conv_s3_reg <= conv_s2_reg;
      sel_s1_reg <= link.diag_sel;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
    end
  end

  assign toggle = conv_s2_reg ^ conv_s3_reg;
  assign sel_rise = sel_s2_reg & ~sel_s3_reg & ~toggle;

  // ========================================================================
  // Mode and side
  logic diag_reg;
  cps_side_t side_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      diag_reg <= 1'b0;
      side_reg <= CPS_SIDE_A;
    end else if (toggle) begin
      diag_reg <= sel_s2_reg;
      side_reg <= conv_s2_reg ? CPS_SIDE_B : CPS_SIDE_A;
    end
  end

  // ========================================================================
  // Integration period measurement
  logic [CNT_W-1:0] period_reg;
  logic cont_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      period_reg <= '0;
      cont_reg <= 1'b0;
    end else if (toggle) begin
      period_reg <= '0;
      cont_reg <= (32'(period_reg) + 32'h0000_0001)
        >= CONT_MIN_CYC;
    end else if (period_reg != '1) begin
      period_reg <= period_reg + 1'b1;
    end
  end

  // ========================================================================
  // Pending packet requests
  logic [PEND_W-1:0] pend_reg;
  logic pend_add;
  logic pend_take;
  cps_dump_state_t ds_reg;

  assign pend_add = (toggle & sel_s2_reg)
    | (sel_rise & diag_reg);
  assign pend_take = (ds_reg == CPS_DS_IDLE) && (pend_reg != '0);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_reg <= '0;
    end else if (toggle & ~sel_s2_reg) begin
      pend_reg <= '0;
    end else if (pend_add & ~pend_take & (pend_reg != '1)) begin
      pend_reg <= pend_reg + 1'b1;
    end else if (~pend_add & pend_take) begin
      pend_reg <= pend_reg - 1'b1;
    end
  end

  // ========================================================================
  // Dump sequencer
  logic [15:0] ds_cnt_reg;
  cps_side_t dump_side_reg;
  logic dump_start;

  assign dump_start = (ds_reg == CPS_DS_BREAK) && (ds_cnt_reg == '0);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ds_reg <= CPS_DS_IDLE;
      ds_cnt_reg <= '0;
      dump_side_reg <= CPS_SIDE_A;
    end else begin
      unique case (ds_reg)
        CPS_DS_IDLE: begin
          if (pend_take && diag_reg) begin
            ds_reg <= CPS_DS_BREAK;
            ds_cnt_reg <= BREAK_CYC - 1'b1;
            dump_side_reg <= side_reg;
          end
        end
        CPS_DS_BREAK: begin
          if (ds_cnt_reg == '0) begin
            ds_reg <= CPS_DS_DUMP;
            ds_cnt_reg <= DUMP_CYC - 1'b1;
          end else begin
            ds_cnt_reg <= ds_cnt_reg - 1'b1;
          end
        end
        CPS_DS_DUMP: begin
          if (ds_cnt_reg == '0) begin
            ds_reg <= CPS_DS_RECHARGE;
            ds_cnt_reg <= RECH_CYC - 1'b1;
          end else begin
            ds_cnt_reg <= ds_cnt_reg - 1'b1;
          end
        end
        CPS_DS_RECHARGE: begin
          if (ds_cnt_reg == '0) begin
            ds_reg <= CPS_DS_IDLE;
          end else begin
            ds_cnt_reg <= ds_cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Switch drive
  logic sa_dump_next;
  logic sb_dump_next;
  logic ref_next;

  always_comb begin
    sa_dump_next = 1'b0;
    sb_dump_next = 1'b0;
    ref_next = 1'b1;
    if ((ds_reg == CPS_DS_BREAK) || (ds_reg == CPS_DS_DUMP)) begin
      ref_next = 1'b0;
    end
    if (dump_start || ((ds_reg == CPS_DS_DUMP) && (ds_cnt_reg != '0))) begin
      sa_dump_next = (dump_side_reg == CPS_SIDE_A);
      sb_dump_next = (dump_side_reg == CPS_SIDE_B);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      side_a_input_switch_o <= 1'b0;
      side_b_input_switch_o <= 1'b0;
      ground_switch_o <= 1'b0;
      side_a_dump_switch_o <= 1'b0;
      side_b_dump_switch_o <= 1'b0;
      reference_charge_switch_o <= 1'b0;
      diag_mode_o <= 1'b0;
      active_side_o <= 1'b0;
      continuous_mode_o <= 1'b0;
    end else begin
      side_a_input_switch_o <= ~diag_reg & (side_reg == CPS_SIDE_A);
      side_b_input_switch_o <= ~diag_reg & (side_reg == CPS_SIDE_B);
      ground_switch_o <= diag_reg;
      side_a_dump_switch_o <= diag_reg & sa_dump_next;
      side_b_dump_switch_o <= diag_reg & sb_dump_next;
      reference_charge_switch_o <= diag_reg & ref_next;
      diag_mode_o <= diag_reg;
      active_side_o <= side_reg;
      continuous_mode_o <= cont_reg;
    end
  end

  // ========================================================================
  // Charge accumulation and conversion
  logic [RES_W:0] acc_sum;
  logic [RES_W-1:0] acc_reg;

  always_comb begin
    acc_sum = {1'b0, acc_reg};
    if (diag_reg) begin
      if (dump_start) begin
        acc_sum = {1'b0, acc_reg} + (RES_W+1)'(PKT_CHARGE);
      end
    end else begin
      acc_sum = {1'b0, acc_reg} + (RES_W+1)'(sensor_charge_i);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_reg <= '0;
      result_o <= '0;
      result_side_o <= 1'b0;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= toggle;
      if (toggle) begin
        result_o <= acc_reg;
        result_side_o <= side_reg;
        acc_reg <= '0;
      end else if (acc_sum[RES_W]) begin
        acc_reg <= '1;
      end else begin
        acc_reg <= acc_sum[RES_W-1:0];
      end
    end
  end

endmodule // cps_device

/* cps_params.svh */
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH

// ==========================================================================
// Clock
`define CPS_CLK_PERIOD_PS 8000

// ==========================================================================
// Result word
`define CPS_RES_W 20

// ==========================================================================
// Timing, times in picoseconds, counts derived from the clock period except CPS_SEL_LOW_CYC
`define CPS_EDGE_SPACE_PS 5400000
`define CPS_EDGE_SPACE_CYC \
  ((`CPS_EDGE_SPACE_PS + `CPS_CLK_PERIOD_PS - 1) / `CPS_CLK_PERIOD_PS)
`define CPS_BREAK_PS 16000
`define CPS_BREAK_CYC \
  ((`CPS_BREAK_PS + `CPS_CLK_PERIOD_PS - 1) / `CPS_CLK_PERIOD_PS)
`define CPS_DUMP_PS 128000
`define CPS_DUMP_CYC \
  ((`CPS_DUMP_PS + `CPS_CLK_PERIOD_PS - 1) / `CPS_CLK_PERIOD_PS)
`define CPS_RECHARGE_PS 128000
`define CPS_RECHARGE_CYC \
  ((`CPS_RECHARGE_PS + `CPS_CLK_PERIOD_PS - 1) / `CPS_CLK_PERIOD_PS)
`define CPS_SEL_LOW_CYC 4

// ==========================================================================
// Defaults
`define CPS_CONT_MIN_CYC 32'h0000_1000
`define CPS_PKT_CHARGE 32'h0000_0400
`define CPS_CNT_W 24
`define CPS_PEND_W 8

`endif

/* cps_pkg.sv */
package cps_pkg;

  // ========================================================================
  // Types
  typedef enum logic {
    CPS_SIDE_A,
    CPS_SIDE_B
  } cps_side_t;

  typedef enum logic [1:0] {
    CPS_DS_IDLE,
    CPS_DS_BREAK,
    CPS_DS_DUMP,
    CPS_DS_RECHARGE
  } cps_dump_state_t;

  typedef enum logic [1:0] {
    CPS_CS_HIGH,
    CPS_CS_LOW
  } cps_ctl_state_t;

endpackage

/* cps_link_if.sv */
interface cps_link_if;
  logic conv;
  logic diag_sel;

  modport dev (
    input conv,
    input diag_sel
  );

  modport ctl (
    output conv,
    output diag_sel
  );
endinterface

/* cps_controller.sv */
`include "cps_params.svh"

module cps_controller
  import cps_pkg::*;
#(
  parameter int CNT_W = `CPS_CNT_W
) (
  input wire logic clk_i,
  input wire logic reset_i,
  cps_link_if.ctl link,
  input wire logic run_i,
  input wire logic diag_req_i,
  input wire logic [CNT_W-1:0] period_i,
  input wire logic [7:0] extra_packets_i,
  output logic integration_start_o,
  output logic [7:0] extra_sent_o
);

  localparam logic [CNT_W-1:0] EDGE_CYC = CNT_W'(`CPS_EDGE_SPACE_CYC);
  localparam logic [CNT_W-1:0] LOW_CYC = CNT_W'(`CPS_SEL_LOW_CYC);

  // ========================================================================
  // Integration timing
  logic [CNT_W-1:0] int_cnt_reg;
  logic [CNT_W-1:0] period_reg;
  logic diag_reg;
  logic toggle_now;

  assign toggle_now = run_i && (int_cnt_reg == '0);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      int_cnt_reg <= '0;
      period_reg <= '0;
      link.conv <= 1'b0;
      diag_reg <= 1'b0;
      integration_start_o <= 1'b0;
    end else begin
      integration_start_o <= toggle_now;
      if (toggle_now) begin
        link.conv <= ~link.conv;
        int_cnt_reg <= period_i - 1'b1;
        period_reg <= period_i;
        diag_reg <= diag_req_i;
      end else if (int_cnt_reg != '0) begin
        int_cnt_reg <= int_cnt_reg - 1'b1;
      end
    end
  end

  // ========================================================================
  // Select pin: level at toggles, extra packet pulses between
  cps_ctl_state_t cs_reg;
  logic [CNT_W-1:0] gap_reg;
  logic [CNT_W-1:0] low_reg;
  logic [7:0] want_reg;
  logic room;

  // Pulse only if it ends well before the toggle and fits the spacing
  assign room = (int_cnt_reg > (LOW_CYC + LOW_CYC))
    && (gap_reg >= EDGE_CYC);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_reg <= CPS_CS_HIGH;
      gap_reg <= '0;
      low_reg <= '0;
      want_reg <= '0;
      extra_sent_o <= '0;
      link.diag_sel <= 1'b0;
    end else begin
      if (gap_reg != '1) begin
        gap_reg <= gap_reg + 1'b1;
      end
      unique case (cs_reg)
        CPS_CS_HIGH: begin
          if (toggle_now) begin
            gap_reg <= '0;
            want_reg <= diag_req_i ? extra_packets_i : 8'h00;
            extra_sent_o <= '0;
          end else if (diag_reg && (want_reg != '0) && room) begin
            cs_reg <= CPS_CS_LOW;
            low_reg <= LOW_CYC - 1'b1;
            link.diag_sel <= 1'b0;
          end else begin
            link.diag_sel <= diag_req_i;
          end
        end
        CPS_CS_LOW: begin
          if (low_reg == '0) begin
            cs_reg <= CPS_CS_HIGH;
            link.diag_sel <= 1'b1;
            gap_reg <= '0;
            want_reg <= want_reg - 1'b1;
            extra_sent_o <= extra_sent_o + 1'b1;
          end else begin
            low_reg <= low_reg - 1'b1;
          end
        end
        default: begin
          cs_reg <= CPS_CS_HIGH;
        end
      endcase
    end
  end

endmodule // cps_controller

/* cps_link_checker.sv */
module cps_link_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic conv,
  input wire logic diag_sel,
  input wire logic diag_mode_o,
  input wire logic active_side_o,
  input wire logic ground_switch_o,
  input wire logic side_a_input_switch_o,
  input wire logic side_b_input_switch_o,
  input wire logic side_a_dump_switch_o,
  input wire logic side_b_dump_switch_o,
  input wire logic reference_charge_switch_o,
  input wire logic result_valid_o
);
  // ==========================================================
  // Helpers
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic any_dump;
  logic conv_reg;
  logic sel_reg;
  logic [15:0] gap_reg;
  assign any_dump = side_a_dump_switch_o | side_b_dump_switch_o;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_reg <= 1'b0;
      sel_reg <= 1'b0;
    end else begin
      conv_reg <= conv;
      sel_reg <= diag_sel;
    end
  end
  // Cycles since last toggle or select rise
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_reg <= 16'h0000;
    end else if ((conv != conv_reg) || (diag_sel && !sel_reg)) begin
      gap_reg <= 16'h0000;
    end else if (gap_reg != 16'hFFFF) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end
  // ==========================================================
  // Sequences
  sequence toggle_s;
    $changed(conv);
  endsequence
  sequence diag_start_s;
    toggle_s ##4 diag_mode_o;
  endsequence
  sequence dump_s;
    any_dump [*8];
  endsequence
  // ==========================================================
  // Assertions
  a_mode_at_toggle: assert property (toggle_s |-> ##4
    diag_mode_o == $past(diag_sel, 4)) else $error("mode not sampled");
  a_mode_only_toggle: assert property ($changed(diag_mode_o) |->
    $past(conv, 4) != $past(conv, 5)) else $error("mode moved");
  a_side_at_toggle: assert property (toggle_s |-> ##4
    active_side_o == $past(conv, 4)) else $error("side wrong");
  a_result_per_int: assert property (toggle_s |-> ##3
    result_valid_o) else $error("no result");
  a_ground_in_diag: assert property (diag_mode_o &&
    $past(diag_mode_o) |-> ground_switch_o) else $error("not grounded");
  a_steer_open: assert property (diag_mode_o && $past(diag_mode_o)
    |-> !side_a_input_switch_o && !side_b_input_switch_o)
    else $error("steering closed");
  a_break_first: assert property ($rose(any_dump) |->
    !reference_charge_switch_o && $past(reference_charge_switch_o) == 0)
    else $error("no break");
  a_recharge_after: assert property ($fell(any_dump) && diag_mode_o
    |-> ##[0:1] reference_charge_switch_o) else $error("no recharge");
  a_dump_side: assert property ($rose(any_dump) |->
    side_b_dump_switch_o == active_side_o &&
    side_a_dump_switch_o == !active_side_o) else $error("wrong side");
  a_packet_start: assert property (diag_start_s |->
    ##[0:8] dump_s) else $error("no packet");
  a_sel_spacing: assert property ($rose(diag_sel) && diag_mode_o
    && conv == $past(conv, 4) |-> gap_reg >= 16'h02A2)
    else $error("rises too close");
  a_sel_before_toggle: assert property ($rose(diag_sel) &&
    diag_mode_o |=> $stable(conv) [*3]) else $error("late restore");
endmodule // cps_link_checker

/* tb_top.sv */
`include "cps_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 12;
  localparam int HD [7] = '{0, 0, 1, 1, 1, 1, 0};
  localparam int HE [7] = '{0, 0, 0, 0, 3, 1, 0};
  localparam int HP [7] = '{4095, 4096, 700, 3000, 2900, 4200, 500};
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic run_i = 1'b0;
  logic diag_req_i = 1'b0;
  logic [23:0] period_i = 24'h00_0040;
  logic [7:0] extra_packets_i = 8'h00;
  logic [7:0] sensor_charge_i = 8'h01;
  logic diag_mode_o, active_side_o, continuous_mode_o, ground_switch_o;
  logic side_a_input_switch_o, side_b_input_switch_o;
  logic side_a_dump_switch_o, side_b_dump_switch_o;
  logic reference_charge_switch_o, result_side_o, result_valid_o, start;
  logic [19:0] result_o;
  logic [7:0] sent;
  int last_sent = 0;
  int seed = 12;
  int fails = 0;
  int n_tests = 0;
  int cfg_d [N+1];
  int cfg_e [N+1];
  int cfg_p [N+1];

  cps_link_if cps_link_if_inst ();
  cps_device cps_device_inst (.clk_i(clk_i), .reset_i(reset_i),
    .link(cps_link_if_inst), .sensor_charge_i(sensor_charge_i),
    .diag_mode_o(diag_mode_o), .active_side_o(active_side_o),
    .continuous_mode_o(continuous_mode_o),
    .side_a_input_switch_o(side_a_input_switch_o),
    .side_b_input_switch_o(side_b_input_switch_o),
    .ground_switch_o(ground_switch_o),
    .side_a_dump_switch_o(side_a_dump_switch_o),
    .side_b_dump_switch_o(side_b_dump_switch_o),
    .reference_charge_switch_o(reference_charge_switch_o),
    .result_o(result_o), .result_side_o(result_side_o),
    .result_valid_o(result_valid_o));
  cps_controller cps_controller_inst (.clk_i(clk_i), .reset_i(reset_i),
    .link(cps_link_if_inst), .run_i(run_i), .diag_req_i(diag_req_i),
    .period_i(period_i), .extra_packets_i(extra_packets_i),
    .integration_start_o(start), .extra_sent_o(sent));
  cps_link_checker cps_link_checker_inst (.clk_i(clk_i),
    .reset_i(reset_i), .conv(cps_link_if_inst.conv),
    .diag_sel(cps_link_if_inst.diag_sel), .diag_mode_o(diag_mode_o),
    .active_side_o(active_side_o), .ground_switch_o(ground_switch_o),
    .side_a_input_switch_o(side_a_input_switch_o),
    .side_b_input_switch_o(side_b_input_switch_o),
    .side_a_dump_switch_o(side_a_dump_switch_o),
    .side_b_dump_switch_o(side_b_dump_switch_o),
    .reference_charge_switch_o(reference_charge_switch_o),
    .result_valid_o(result_valid_o));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // ==========================================================
  // Checking
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("TB: %0d checks, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_start;
    int k;
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
      if (start !== 1'b1) begin
        last_sent = sent;
      end
    end while (start !== 1'b1 && k < 6000);
    if (k >= 6000) begin
      fails++;
      end_of_test;
    end
  endtask

  function automatic logic [31:0] exp_diag(input int e);
    return `CPS_PKT_CHARGE * (e + 1);
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    int i;
    int s;
    int p;
    s = {$random(seed)} % 127 + 1;
    sensor_charge_i = s[7:0];
    for (i = 0; i < N; i++) begin
      if (i < 7) begin
        cfg_d[i] = HD[i];
        cfg_e[i] = HE[i];
        cfg_p[i] = HP[i];
      end else begin
        cfg_d[i] = {$random(seed)} % 2;
        cfg_e[i] = cfg_d[i] ? {$random(seed)} % 4 : 0;
        cfg_p[i] = (cfg_e[i] + 1) * 700 + {$random(seed)} % 1024 + 64;
      end
    end
    // Config held after the last update
    cfg_d[N] = cfg_d[N-1];
    cfg_e[N] = cfg_e[N-1];
    cfg_p[N] = cfg_p[N-1];
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    run_i <= 1'b1;
    for (i = 0; i < N + 2; i++) begin
      wait_start;
      @(posedge clk_i);
      if (i < N) begin
        diag_req_i <= cfg_d[i][0];
        extra_packets_i <= cfg_e[i][7:0];
        period_i <= cfg_p[i][23:0];
      end
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      if (i >= 1) begin
        check(diag_mode_o, cfg_d[i-1][0]);
        check(ground_switch_o, cfg_d[i-1][0]);
        check(active_side_o, cps_link_if_inst.conv);
        check({side_b_input_switch_o, side_a_input_switch_o},
              cfg_d[i-1] != 0 ? 0 : (cps_link_if_inst.conv ? 2 : 1));
      end
      if (i >= 2) begin
        p = cfg_p[i-2];
        if (cfg_d[i-2] != 0) begin
          check(result_o, exp_diag(cfg_e[i-2]));
        end else begin
          check(result_o >= s * (p - 1) && result_o <= s * (p + 1),
                1);
        end
        check(continuous_mode_o, p >= `CPS_CONT_MIN_CYC);
        check(result_side_o, !active_side_o);
        check(last_sent, cfg_e[i-2]);
      end
      $display("TB: integration %0d done", i);
    end
    end_of_test;
  end
endmodule // tb_top
